// *** rtl/dcsz_pkg.sv ***
package dcsz_pkg;
  // register byte addresses (one aligned word each)
  localparam logic [3:0] SRC_LEN_ADDR = 4'h0;
  localparam logic [3:0] DST_LEN_ADDR = 4'h4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int LEN_W = 16;
  localparam int BLK_W = 17;
  // field layout and reset values
  localparam logic [15:0] LEN_RESET = 16'h0000;
  localparam logic [15:0] LEN_ZERO = 16'h0000;
  localparam logic [16:0] LEN_MAX_BYTES = 17'h10000;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/dcsz_len_reg.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcsz_len_reg (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [3:0] wstrb,
  input wire logic [31:0] wdata,
  output logic [15:0] field,
  output logic [16:0] block_bytes
);
  logic [15:0] field_r;
  logic [15:0] field_nxt;
  logic [16:0] bytes_r;
  logic [16:0] bytes_nxt;

  // byte-lane update of the low half only; upper lanes are dropped
  always_comb begin
    field_nxt = field_r;
    if (wr_en) begin
      if (wstrb[0]) begin
        field_nxt[7:0] = wdata[7:0];
      end
      if (wstrb[1]) begin
        field_nxt[15:8] = wdata[15:8];
      end
    end
    // zero selects the maximum block length
    if (field_nxt == dcsz_pkg::LEN_ZERO) begin
      bytes_nxt = dcsz_pkg::LEN_MAX_BYTES;
    end else begin
      bytes_nxt = {1'b0, field_nxt};
    end
  end

  // state registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      field_r <= dcsz_pkg::LEN_RESET;
      bytes_r <= dcsz_pkg::LEN_MAX_BYTES;
    end else begin
      field_r <= field_nxt;
      bytes_r <= bytes_nxt;
    end
  end

  assign field = field_r;
  assign block_bytes = bytes_r;
endmodule
`default_nettype wire

// *** rtl/dcsz_size_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcsz_size_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [16:0] source_block_bytes,
  output logic [16:0] destination_block_bytes
);
  logic aw_held_r;
  logic aw_held_nxt;
  logic w_held_r;
  logic w_held_nxt;
  // write acceptance pulses
  logic awready_r;
  logic awready_nxt;
  logic wready_r;
  logic wready_nxt;
  logic [3:0] awaddr_r;
  logic [3:0] awaddr_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic [3:0] wstrb_r;
  logic [3:0] wstrb_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic arready_r;
  logic arready_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic do_write;
  logic src_wr;
  logic dst_wr;
  logic [15:0] source_length_field;
  logic [15:0] destination_length_field;
  logic [16:0] src_bytes;
  logic [16:0] dst_bytes;

  // write channel: take address and data in either order, answer after both
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    do_write = 1'b0;
    src_wr = 1'b0;
    dst_wr = 1'b0;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_held_r && w_held_r && !bvalid_r) begin
      do_write = 1'b1;
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      src_wr = (awaddr_r == dcsz_pkg::SRC_LEN_ADDR);
      dst_wr = (awaddr_r == dcsz_pkg::DST_LEN_ADDR);
      bresp_nxt = (src_wr || dst_wr) ? dcsz_pkg::RESP_OKAY : dcsz_pkg::RESP_SLVERR;
    end
  end

  // write channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= dcsz_pkg::RESP_OKAY;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
    end
  end

  // address and data acceptance: registered one-cycle ready pulses
  always_comb begin
    awready_nxt = 1'b0;
    wready_nxt = 1'b0;
    if (s_axi_awvalid && !awready_r && !aw_held_r && !bvalid_r) begin
      awready_nxt = 1'b1; // ready raised at the next edge, address taken at the edge after
    end
    if (s_axi_wvalid && !wready_r && !w_held_r && !bvalid_r) begin
      wready_nxt = 1'b1; // ready raised at the next edge, data taken at the edge after
    end
  end

  // ready pulse registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
    end
  end

  // source length register
  dcsz_len_reg u_src (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(src_wr),
    .wstrb(wstrb_r),
    .wdata(wdata_r),
    .field(source_length_field),
    .block_bytes(src_bytes)
  );

  // destination length register
  dcsz_len_reg u_dst (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(dst_wr),
    .wstrb(wstrb_r),
    .wdata(wdata_r),
    .field(destination_length_field),
    .block_bytes(dst_bytes)
  );

  // read channel: one read at a time, data registered
  always_comb begin
    arready_nxt = 1'b0;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !arready_r && !rvalid_r) begin
      arready_nxt = 1'b1;
      rvalid_nxt = 1'b1;
      rresp_nxt = dcsz_pkg::RESP_OKAY;
      if (s_axi_araddr == dcsz_pkg::SRC_LEN_ADDR) begin
        rdata_nxt = {dcsz_pkg::UPPER_ZERO, source_length_field};
      end else if (s_axi_araddr == dcsz_pkg::DST_LEN_ADDR) begin
        rdata_nxt = {dcsz_pkg::UPPER_ZERO, destination_length_field};
      end else begin
        rdata_nxt = 32'h00000000;
        rresp_nxt = dcsz_pkg::RESP_SLVERR;
      end
    end
  end

  // read channel registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= dcsz_pkg::RESP_OKAY;
    end else begin
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign source_block_bytes = src_bytes;
  assign destination_block_bytes = dst_bytes;
endmodule
`default_nettype wire

// *** verification/dcsz_size_regs_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcsz_size_regs_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [16:0] source_block_bytes,
  input wire logic [16:0] destination_block_bytes
);
  // bus clock, quiet in reset
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // lengths, reset values, read path, write handshakes
  a_src_range: assert property (source_block_bytes inside {[17'h1:17'h10000]})
    else $error("src len");
  a_dst_range: assert property (destination_block_bytes inside {[17'h1:17'h10000]})
    else $error("dst len");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
    else $error("upper half");
  a_reset_max: assert property ($rose(aresetn) |-> (source_block_bytes & destination_block_bytes) == 17'h10000)
    else $error("reset len");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |-> ##[1:2] s_axi_rvalid)
    else $error("no read answer");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("wready held");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  // main scenarios
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_src_max: cover property (source_block_bytes == 17'h10000);
  c_dst_one: cover property (destination_block_bytes == 17'h1);
endmodule
`default_nettype wire

// *** verification/dcsz_size_regs_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module dcsz_size_regs_tb;
  localparam logic [3:0] sa = dcsz_pkg::SRC_LEN_ADDR;
  localparam logic [3:0] da = dcsz_pkg::DST_LEN_ADDR;
  logic aclk = 1'h0, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [16:0] source_block_bytes, destination_block_bytes;
  int failures = 0, samples_checked = 0;
  dcsz_size_regs dcsz_size_regs_i (.*);
  // 4 ns clock
  initial forever #2 aclk = ~aclk;
  // compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %0t: %h not %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // one write, address and data offered together, response compared
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] r = dcsz_pkg::RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    @(posedge aclk);
  endtask
  // one read, data and response compared
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r = dcsz_pkg::RESP_OKAY);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    @(posedge aclk);
  endtask
  // reset for 4 cycles, then both lengths at maximum
  task automatic t_reset;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({15'h0, source_block_bytes}, 32'h10000);
    chk({15'h0, destination_block_bytes}, 32'h10000);
    rd(sa, 32'h0);
    rd(da, 32'h0);
  endtask
  // upper half ignored, lengths taken as written
  task automatic t_write;
    wr(sa, 32'hFFFF1234);
    wr(da, 32'hABCD0001);
    rd(sa, 32'h1234);
    rd(da, 32'h1);
    chk({15'h0, source_block_bytes}, 32'h1234);
    chk({15'h0, destination_block_bytes}, 32'h1);
  endtask
  // largest count and zero count
  task automatic t_zero;
    wr(sa, 32'hFFFF);
    chk({15'h0, source_block_bytes}, 32'hFFFF);
    wr(sa, 32'h0);
    wr(da, 32'h0);
    chk({15'h0, source_block_bytes}, 32'h10000);
    chk({15'h0, destination_block_bytes}, 32'h10000);
    wr(da, 32'h7);
    wr(da, 32'h0000AB12, 4'h2);
    chk({15'h0, destination_block_bytes}, 32'hAB07);
    rd(da, 32'hAB07);
  endtask
  // unmapped read and write refused, lengths untouched
  task automatic t_unmapped;
    rd(4'h8, 32'h0, dcsz_pkg::RESP_SLVERR);
    wr(4'h8, 32'h00005555, 4'hF, dcsz_pkg::RESP_SLVERR);
    rd(sa, 32'h0);
    rd(da, 32'hAB07);
  endtask
  // main sequence, second reset at the end
  initial begin
    t_reset;
    t_write;
    t_zero;
    t_unmapped;
    t_reset;
    report_and_stop;
  end
  // watchdog
  initial begin
    #20000;
    failures++;
    report_and_stop;
  end
endmodule
bind dcsz_size_regs dcsz_size_regs_chk dcsz_size_regs_chk_i (.*);
`default_nettype wire
